/* rtl/tsrb_map.svh */
`ifndef TSRB_MAP_SVH
`define TSRB_MAP_SVH

// Pointer codes
`define TSRB_PTR_RESULT 2'h0
`define TSRB_PTR_SETUP 2'h1
`define TSRB_PTR_LOW 2'h2
`define TSRB_PTR_HIGH 2'h3

// Reset values
`define TSRB_SETUP_RST 16'h40a0
`define TSRB_LOW_RST 16'h4b00
`define TSRB_HIGH_RST 16'h5000
`define TSRB_RESULT_RST 16'h0000

// Setup field layout
`define TSRB_SETUP_WMASK 16'h9fd0
`define TSRB_SETUP_FIXED 16'h4000
`define TSRB_THR_MASK 16'hfff0
`define TSRB_B_FLAG 5
`define TSRB_B_RATE 6
`define TSRB_B_SHUT 8
`define TSRB_B_LATCH 9
`define TSRB_B_POL 10
`define TSRB_B_FAULT 11

// Sample rate and fault count codes
`define TSRB_RATE_Q 2'h0
`define TSRB_RATE_1 2'h1
`define TSRB_RATE_4 2'h2
`define TSRB_RATE_8 2'h3
`define TSRB_FAULT_N0 3'h1
`define TSRB_FAULT_N1 3'h2
`define TSRB_FAULT_N2 3'h4
`define TSRB_FAULT_N3 3'h6

// Timing
`define TSRB_CLK_KHZ 20000
`define TSRB_CONV_MS 34
`define TSRB_PER_Q_MS 4000
`define TSRB_PER_1_MS 1000
`define TSRB_PER_4_MS 250
`define TSRB_PER_8_MS 125

`endif

/* rtl/tsrb_pkg.sv */
package tsrb_pkg;

  typedef enum logic [2:0] {
    ST_CONV = 3'b001,
    ST_STBY = 3'b010,
    ST_SLEEP = 3'b100
  } state_type;

endpackage

/* rtl/tsrb_register_bank.sv */
`include "tsrb_map.svh"
// Summary of operation
// - Pointer is eight bits; only two low bits store, upper six read zero.
// - Pointer 0 result, 1 setup, 2 lower threshold, 3 upper threshold.
// - Result is read-only; setup and thresholds are readable and writable.
// - Sixteen-bit words move most significant byte first, then least.
// - Setup bits 0-3 and 13-14 are fixed at default, writes ignored.
// - Polarity low: flag reads 1 until upper threshold met N times, then 0.
// - Flag then stays 0 until lower threshold met N times, then returns 1.
// - Polarity bit inverts the active level of the limit flag.
// - In comparator style the flag equals the limit pin level.
// - Result changes only when a conversion completes.
// - Rate field 00/01/10/11 gives 0.25, 1, 4, 8 conversions per second.
// - Reset rate is one conversion every 250 ms.
// - First conversion starts right after reset; result after 34 ms.
// - Between conversions the block sits in standby until the timer fires.
// - Fault field 00/01/10/11 needs 1, 2, 4, 6 successive hits.
// - Thresholds hold twelve bits in 15:4; bits 3:0 read zero.
// - Polarity clear drives pin active low; set drives it active high.
module tsrb_register_bank #(
  parameter int unsigned CONV_CYC = `TSRB_CONV_MS * `TSRB_CLK_KHZ,
  parameter int unsigned PER_Q_CYC = `TSRB_PER_Q_MS * `TSRB_CLK_KHZ,
  parameter int unsigned PER_1_CYC = `TSRB_PER_1_MS * `TSRB_CLK_KHZ,
  parameter int unsigned PER_4_CYC = `TSRB_PER_4_MS * `TSRB_CLK_KHZ,
  parameter int unsigned PER_8_CYC = `TSRB_PER_8_MS * `TSRB_CLK_KHZ
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic xferStart,
  input wire logic ptrWrEn,
  input wire logic [7:0] ptrWrData,
  input wire logic dataWrEn,
  input wire logic [7:0] dataWrByte,
  input wire logic dataRdEn,
  input wire logic [11:0] adcCode,
  output logic [7:0] ptrRdData,
  output logic [7:0] rdByte,
  output logic convActive,
  output logic standby,
  output logic alertPin
);

  logic [1:0] ptr_q, ptr_d;
  logic phase_q, phase_d;
  logic [7:0] wrHold_q, wrHold_d;
  logic [15:0] rdHold_q, rdHold_d;
  logic [7:0] rdByte_q, rdByte_d;
  logic [15:0] setup_q, setup_d;
  logic [15:0] low_q, low_d;
  logic [15:0] high_q, high_d;
  logic [15:0] result_q, result_d;
  tsrb_pkg::state_type state_q, state_d;
  logic [31:0] timer_q, timer_d;
  logic [31:0] period_q, period_d;
  logic faultState_q, faultState_d;
  logic [2:0] faultCnt_q, faultCnt_d;
  logic intPend_q, intPend_d;

  logic active_level_sel, latchStyle, shut;
  logic [1:0] rateSel, faultSel;
  logic limitFlag, pinActive, commit, resultLoad, convStart, toggled, faultHit;
  logic [15:0] wrWord, setupRead, regRead;
  logic [2:0] faultNeed;

  assign active_level_sel = setup_q[`TSRB_B_POL];
  assign latchStyle = setup_q[`TSRB_B_LATCH];
  assign shut = setup_q[`TSRB_B_SHUT];
  assign rateSel = setup_q[`TSRB_B_RATE +: 2];
  assign faultSel = setup_q[`TSRB_B_FAULT +: 2];
  assign limitFlag = faultState_q ? active_level_sel : ~active_level_sel;
  assign pinActive = latchStyle ? intPend_q : faultState_q;
  assign alertPin = pinActive ? active_level_sel : ~active_level_sel;
  assign setupRead = setup_q | `TSRB_SETUP_FIXED | ({15'h0000, limitFlag} << `TSRB_B_FLAG);
  assign wrWord = {wrHold_q, dataWrByte};
  assign commit = dataWrEn & phase_q;
  assign ptrRdData = {6'h00, ptr_q};
  assign rdByte = rdByte_q;
  assign convActive = (state_q == tsrb_pkg::ST_CONV);
  assign standby = ~convActive;

  always_comb begin
    case (ptr_q)
      `TSRB_PTR_RESULT: regRead = result_q;
      `TSRB_PTR_SETUP: regRead = setupRead;
      `TSRB_PTR_LOW: regRead = low_q;
      default: regRead = high_q;
    endcase
  end

  always_comb begin
    case (faultSel)
      2'h0: faultNeed = `TSRB_FAULT_N0;
      2'h1: faultNeed = `TSRB_FAULT_N1;
      2'h2: faultNeed = `TSRB_FAULT_N2;
      default: faultNeed = `TSRB_FAULT_N3;
    endcase
  end

  always_comb begin
    ptr_d = ptr_q;
    phase_d = phase_q;
    wrHold_d = wrHold_q;
    rdHold_d = rdHold_q;
    rdByte_d = rdByte_q;
    setup_d = setup_q;
    low_d = low_q;
    high_d = high_q;
    if (ptrWrEn) begin
      ptr_d = ptrWrData[1:0];
    end
    if (ptrWrEn || xferStart) begin
      phase_d = 1'b0;
    end else if (dataWrEn || dataRdEn) begin
      phase_d = ~phase_q;
    end
    if (dataWrEn && !phase_q) begin
      wrHold_d = dataWrByte;
    end
    if (commit) begin
      case (ptr_q)
        `TSRB_PTR_SETUP: setup_d = (setup_q & ~`TSRB_SETUP_WMASK) | (wrWord & `TSRB_SETUP_WMASK);
        `TSRB_PTR_LOW: low_d = wrWord & `TSRB_THR_MASK;
        `TSRB_PTR_HIGH: high_d = wrWord & `TSRB_THR_MASK;
        default: setup_d = setup_q;
      endcase
    end
    // Word snapshot so both bytes come from one value
    if (dataRdEn) begin
      if (!phase_q) begin
        rdHold_d = regRead;
        rdByte_d = regRead[15:8];
      end else begin
        rdByte_d = rdHold_q[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ptr_q <= `TSRB_PTR_RESULT;
      phase_q <= 1'b0;
      wrHold_q <= 8'h00;
      rdHold_q <= 16'h0000;
      rdByte_q <= 8'h00;
      setup_q <= `TSRB_SETUP_RST & `TSRB_SETUP_WMASK;
      low_q <= `TSRB_LOW_RST;
      high_q <= `TSRB_HIGH_RST;
    end else begin
      ptr_q <= ptr_d;
      phase_q <= phase_d;
      wrHold_q <= wrHold_d;
      rdHold_q <= rdHold_d;
      rdByte_q <= rdByte_d;
      setup_q <= setup_d;
      low_q <= low_d;
      high_q <= high_d;
    end
  end

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    period_d = period_q;
    result_d = result_q;
    faultState_d = faultState_q;
    faultCnt_d = faultCnt_q;
    intPend_d = intPend_q;
    convStart = 1'b0;
    resultLoad = 1'b0;
    toggled = 1'b0;
    case (state_q)
      tsrb_pkg::ST_CONV: begin
        timer_d = timer_q + 32'h1;
        if (timer_q == CONV_CYC - 1) begin
          resultLoad = 1'b1;
          state_d = tsrb_pkg::ST_STBY;
        end
      end
      tsrb_pkg::ST_STBY: begin
        timer_d = timer_q + 32'h1;
        if (timer_q >= period_q - 1) begin
          timer_d = 32'h0;
          if (shut) begin
            state_d = tsrb_pkg::ST_SLEEP;
          end else begin
            convStart = 1'b1;
          end
        end
      end
      tsrb_pkg::ST_SLEEP: begin
        convStart = ~shut;
      end
      default: begin
        state_d = tsrb_pkg::ST_CONV;
        timer_d = 32'h0;
      end
    endcase
    if (convStart) begin
      state_d = tsrb_pkg::ST_CONV;
      timer_d = 32'h0;
      case (rateSel)
        `TSRB_RATE_Q: period_d = PER_Q_CYC;
        `TSRB_RATE_1: period_d = PER_1_CYC;
        `TSRB_RATE_4: period_d = PER_4_CYC;
        default: period_d = PER_8_CYC;
      endcase
    end
    // Thresholds count as hit when equalled
    faultHit = faultState_q ? ($signed(adcCode) <= $signed(low_q[15:4]))
                            : ($signed(adcCode) >= $signed(high_q[15:4]));
    if (resultLoad) begin
      result_d = {adcCode, 4'h0};
      if (faultHit) begin
        if (faultCnt_q + 3'h1 >= faultNeed) begin
          faultState_d = ~faultState_q;
          faultCnt_d = 3'h0;
          toggled = 1'b1;
        end else begin
          faultCnt_d = faultCnt_q + 3'h1;
        end
      end else begin
        faultCnt_d = 3'h0;
      end
    end
    // Latched style: any read or sleep clears, new event wins
    if (dataRdEn || shut || !latchStyle) begin
      intPend_d = 1'b0;
    end
    if (toggled && latchStyle) begin
      intPend_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= tsrb_pkg::ST_CONV;
      timer_q <= 32'h0;
      period_q <= PER_4_CYC;
      result_q <= `TSRB_RESULT_RST;
      faultState_q <= 1'b0;
      faultCnt_q <= 3'h0;
      intPend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      period_q <= period_d;
      result_q <= result_d;
      faultState_q <= faultState_d;
      faultCnt_q <= faultCnt_d;
      intPend_q <= intPend_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_ptr_upper_zero: assert property (ptrWrEn |=> ptrRdData == {6'h00, $past(ptrWrData[1:0])})
    else $error("pointer upper bits not zero");
  a_ptr_read_route: assert property ((dataRdEn && !phase_q && ptr_q == `TSRB_PTR_LOW) |=> rdByte == low_q[15:8])
    else $error("pointer routing wrong");
  a_result_not_written: assert property ((commit && ptr_q == `TSRB_PTR_RESULT && !resultLoad) |=> $stable(result_q))
    else $error("result written by host");
  a_byte_order_lsb: assert property ((dataRdEn && !phase_q && !ptrWrEn && !xferStart) ##1 (dataRdEn && !ptrWrEn)
    |=> rdByte == $past(rdHold_q[7:0], 1))
    else $error("lsb byte mismatch");
  a_setup_fixed_bits: assert property (setupRead[3:0] == 4'h0 && setupRead[14:13] == 2'b10)
    else $error("setup fixed bits changed");
  a_flag_polarity: assert property (setupRead[`TSRB_B_FLAG] == (faultState_q ~^ active_level_sel))
    else $error("flag polarity wrong");
  a_flag_set_cause: assert property ($rose(faultState_q) |-> $past(resultLoad) && $past(faultHit))
    else $error("flag set without fault");
  a_flag_clear_cause: assert property ($fell(faultState_q) |-> $past(resultLoad) && $past(faultHit))
    else $error("flag cleared without fault");
  a_flag_pin_match: assert property (!latchStyle |-> setupRead[`TSRB_B_FLAG] == alertPin)
    else $error("flag differs from pin");
  a_result_stable: assert property (!resultLoad |=> $stable(result_q))
    else $error("result changed outside completion");
  a_rate_period: assert property ((convStart && rateSel == `TSRB_RATE_8) |=> period_q == PER_8_CYC)
    else $error("rate period wrong");
  a_reset_period: assert property ($rose(nrst) |-> period_q == PER_4_CYC && convActive)
    else $error("reset rate or start wrong");
  a_conv_length: assert property ($fell(convActive) |-> $past(timer_q) == CONV_CYC - 1)
    else $error("conversion length wrong");
  a_standby_idle: assert property (standby |-> !resultLoad && state_q != tsrb_pkg::ST_CONV)
    else $error("standby during conversion");
  a_fault_count_max: assert property (faultCnt_q < faultNeed || !$stable(faultSel))
    else $error("fault count overrun");
  a_thr_nibble_zero: assert property (low_q[3:0] == 4'h0 && high_q[3:0] == 4'h0)
    else $error("threshold nibble set");
  a_pin_active_low: assert property ((pinActive && !active_level_sel) |-> !alertPin)
    else $error("pin polarity wrong");
  a_ptr_persist: assert property (!ptrWrEn |=> $stable(ptr_q))
    else $error("pointer changed");
  a_rate_no_abort: assert property ((convActive && !convStart) |=> $stable(period_q))
    else $error("period changed mid conversion");

  c_conv_done: cover property (resultLoad ##1 standby);
  c_flag_trip: cover property ($rose(faultState_q));
  c_latched_read: cover property (intPend_q ##1 dataRdEn);
  c_setup_write: cover property (commit && ptr_q == `TSRB_PTR_SETUP);

endmodule // tsrb_register_bank

/* tb/tsrb_host_model.sv */
module tsrb_host_model (
  input wire logic clock,
  input wire logic [7:0] rdByte,
  output logic xferStart,
  output logic ptrWrEn,
  output logic [7:0] ptrWrData,
  output logic dataWrEn,
  output logic [7:0] dataWrByte,
  output logic dataRdEn
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {xferStart, ptrWrEn, dataWrEn, dataRdEn} = 4'h0;
    ptrWrData = 8'h00;
    dataWrByte = 8'h00;
  end

  // Upper pointer bits sent as ones on purpose; released data inverted
  task automatic setPtr(input logic [1:0] p);
    @(negedge clock) ptrWrEn = 1'b1;
    ptrWrData = {6'h3f, p};
    @(negedge clock) ptrWrEn = 1'b0;
    ptrWrData = ~ptrWrData;
  endtask

  // MSB first, setup bit 4 left alone by callers
  task automatic wrWord(input logic [1:0] p, input logic [15:0] w);
    setPtr(p);
    dataWrEn = 1'b1;
    dataWrByte = w[15:8];
    @(negedge clock) dataWrByte = w[7:0];
    @(negedge clock) dataWrEn = 1'b0;
    dataWrByte = ~dataWrByte;
  endtask

  task automatic rdBody(output logic [15:0] w);
    dataRdEn = 1'b1;
    @(negedge clock) w[15:8] = rdByte;
    @(negedge clock) w[7:0] = rdByte;
    dataRdEn = 1'b0;
  endtask

  task automatic rdWord(input logic [1:0] p, output logic [15:0] w);
    setPtr(p);
    rdBody(w);
  endtask

  // New transaction, pointer kept
  task automatic rdCur(output logic [15:0] w);
    @(negedge clock) xferStart = 1'b1;
    @(negedge clock) xferStart = 1'b0;
    rdBody(w);
  endtask
endmodule // tsrb_host_model

/* tb/tb_temp_sensor_register_bank.sv */
`include "tsrb_map.svh"
module tb_temp_sensor_register_bank;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 20;
  localparam int PER [4] = '{200, 100, 60, 40};
  localparam int NF [4] = '{1, 2, 4, 6};
  logic clock, nrst, xferStart, ptrWrEn, dataWrEn, dataRdEn, convActive, standby, alertPin;
  logic [7:0] ptrWrData, dataWrByte, ptrRdData, rdByte;
  logic [11:0] adcCode;
  logic [15:0] rv;
  int n_mismatch = 0;
  int n_tests = 0;

  tsrb_register_bank #(.CONV_CYC(CONV), .PER_Q_CYC(PER[0]), .PER_1_CYC(PER[1]),
    .PER_4_CYC(PER[2]), .PER_8_CYC(PER[3])) dut (.clock(clock), .nrst(nrst),
    .xferStart(xferStart), .ptrWrEn(ptrWrEn), .ptrWrData(ptrWrData), .dataWrEn(dataWrEn),
    .dataWrByte(dataWrByte), .dataRdEn(dataRdEn), .adcCode(adcCode), .ptrRdData(ptrRdData),
    .rdByte(rdByte), .convActive(convActive), .standby(standby), .alertPin(alertPin));

  tsrb_host_model host (.clock(clock), .rdByte(rdByte), .xferStart(xferStart), .ptrWrEn(ptrWrEn),
    .ptrWrData(ptrWrData), .dataWrEn(dataWrEn), .dataWrByte(dataWrByte), .dataRdEn(dataRdEn));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Negedges until convActive reaches lvl; a stuck schedule ends the run
  task automatic waitTo(input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge clock) n++;
    end while (convActive !== lvl && n < 1000);
    if (n >= 1000) begin
      n_mismatch++;
      $display("[ERR] %0t conversion schedule stuck", $time);
      wrap_up();
    end
  endtask

  task automatic t_boot;
    int n;
    chk(16'(convActive), 16'h1);
    waitTo(1'b0, n);
    chk(16'(n), 16'(CONV));
    chk(16'(standby), 16'h1);
    $display("boot test done");
  endtask

  task automatic t_regs;
    host.rdWord(`TSRB_PTR_SETUP, rv);
    chk(rv, 16'h40a0);
    chk({8'h00, ptrRdData}, 16'h0001);
    host.rdWord(`TSRB_PTR_LOW, rv);
    chk(rv, 16'h4b00);
    host.rdWord(`TSRB_PTR_HIGH, rv);
    chk(rv, 16'h5000);
    host.wrWord(`TSRB_PTR_RESULT, 16'hffff);
    host.rdWord(`TSRB_PTR_RESULT, rv);
    chk(rv, 16'h0000);
    host.wrWord(`TSRB_PTR_LOW, 16'h1234);
    host.rdWord(`TSRB_PTR_LOW, rv);
    chk(rv, 16'h1230);
    host.rdCur(rv);
    chk(rv, 16'h1230);
    host.wrWord(`TSRB_PTR_SETUP, 16'hffef);
    host.rdWord(`TSRB_PTR_SETUP, rv);
    chk(rv, 16'hdfc0);
    host.wrWord(`TSRB_PTR_SETUP, 16'h0000);
    host.rdWord(`TSRB_PTR_SETUP, rv);
    chk(rv, 16'h4020);
    $display("register test done");
  endtask

  task automatic t_rates;
    int n, m, k;
    for (int r = 0; r < 4; r++) begin
      host.wrWord(`TSRB_PTR_SETUP, {8'h40, 2'(r), 6'h00});
      waitTo(1'b0, n);
      waitTo(1'b1, n);
      waitTo(1'b0, m);
      waitTo(1'b1, k);
      chk(16'(m + k), 16'(PER[r]));
    end
    $display("rate test done");
  endtask

  task automatic t_alert;
    int n;
    host.wrWord(`TSRB_PTR_HIGH, 16'h0100);
    host.wrWord(`TSRB_PTR_LOW, 16'h0080);
    for (int fc = 0; fc < 4; fc++) begin
      host.wrWord(`TSRB_PTR_SETUP, {3'b010, 2'(fc), 11'h0c0});
      waitTo(1'b1, n);
      waitTo(1'b0, n);
      adcCode = 12'h020;
      for (int k = 1; k <= NF[fc]; k++) begin
        waitTo(1'b1, n);
        waitTo(1'b0, n);
        host.rdWord(`TSRB_PTR_SETUP, rv);
        chk(16'(rv[5]), 16'(k < NF[fc]));
        chk(16'(alertPin), 16'(rv[5]));
      end
      host.rdWord(`TSRB_PTR_RESULT, rv);
      chk(rv, 16'h0200);
      adcCode = 12'h000;
      for (int k = 1; k <= NF[fc]; k++) begin
        waitTo(1'b1, n);
        waitTo(1'b0, n);
        host.rdWord(`TSRB_PTR_SETUP, rv);
        chk(16'(rv[5]), 16'(k >= NF[fc]));
        chk(16'(alertPin), 16'(rv[5]));
      end
    end
    host.wrWord(`TSRB_PTR_SETUP, 16'h44c0);
    host.rdWord(`TSRB_PTR_SETUP, rv);
    chk(rv, 16'h44c0);
    chk(16'(alertPin), 16'h0);
    $display("alert test done");
  endtask

  // Latched style: each trip drives the pin until any read clears it
  task automatic t_latch;
    int n;
    host.wrWord(`TSRB_PTR_SETUP, 16'h42c0);
    adcCode = 12'h020;
    waitTo(1'b1, n);
    waitTo(1'b0, n);
    chk(16'(alertPin), 16'h0);
    host.rdWord(`TSRB_PTR_SETUP, rv);
    chk(rv, 16'h42c0);
    chk(16'(alertPin), 16'h1);
    adcCode = 12'h000;
    waitTo(1'b1, n);
    waitTo(1'b0, n);
    chk(16'(alertPin), 16'h0);
    host.rdWord(`TSRB_PTR_RESULT, rv);
    chk(rv, 16'h0000);
    chk(16'(alertPin), 16'h1);
    $display("latch test done");
  endtask

  initial begin
    nrst = 1'b0;
    adcCode = 12'h000;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    t_boot();
    t_regs();
    t_rates();
    t_alert();
    t_latch();
    wrap_up();
  end
endmodule // tb_temp_sensor_register_bank
